// ==== testbench/serial_flash_instruction_frontend_test.sv ====
// serial_flash_instruction_frontend_test: directed scenarios on the front end.
// assumes: sfe_host drives the pins; this bench models the array engine.
`timescale 1ns/10ps
`default_nettype none

module serial_flash_instruction_frontend_test;
	import sfe_pkg::*;
	localparam logic [7:0] DEVC = 8'h77; // arbitrary value
	logic clk_sys = 1'b0, reset_n = 1'b0, busy = 1'b0, prot_en = 1'b0, prog_ready = 1'b1;
	logic spi_cs_n, spi_sclk, serial_in, serial_out, serial_out_oe, rd_req, prog_valid;
	logic cmd_go, sr_wr, sr_wr_hi_en, sr_wr_volatile, wr_en_latch, power_down;
	logic four_line_command_mode;
	logic [3:0] io_in, io_out, io_oe;
	logic [7:0] status_lo = 8'h00, status_hi = 8'h00, rd_data = 8'h00, prog_data;
	logic [23:0] prot_lo = 24'h0, prot_hi = 24'h0, rd_addr, cmd_addr, go_addr;
	logic [15:0] sr_wr_data;
	sfe_op_t cmd_op, go_op;
	logic [7:0] rx[$], pq[$];
	int go_n = 0, sr_n = 0, g0, err_total = 0, checks_done = 0;

	always #50 clk_sys = ~clk_sys;

	sfe_host h (.clk_sys, .spi_cs_n, .spi_sclk, .serial_in, .io_in, .serial_out, .io_out);

	sfe_frontend #(.DEV_CODE(DEVC), .BUF_DEPTH(2)) u_dut (.clk_sys, .reset_n, .spi_cs_n,
		.spi_sclk, .serial_in, .io_in, .serial_out, .serial_out_oe, .io_out, .io_oe, .busy,
		.status_lo, .status_hi, .prot_en, .prot_lo, .prot_hi, .rd_req, .rd_addr, .rd_data,
		.prog_valid, .prog_data, .prog_ready, .cmd_go, .cmd_op, .cmd_addr, .sr_wr,
		.sr_wr_data, .sr_wr_hi_en, .sr_wr_volatile, .wr_en_latch, .power_down,
		.four_line_command_mode);

	// array engine model and strobe monitors
	always @(posedge clk_sys) begin
		if (cmd_go) begin
			go_n <= go_n + 1;
			go_op <= cmd_op;
			go_addr <= cmd_addr;
		end
		if (sr_wr)
			sr_n <= sr_n + 1;
		if (rd_req)
			rd_data <= rd_addr[7:0] ^ 8'h3c;
		if (prog_valid && prog_ready)
			pq.push_back(prog_data);
	end

	task chk(input logic [63:0] g, input logic [63:0] e);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask

	task run(input logic [7:0] tx[$], input int bits);
		h.frame(tx, bits, rx);
	endtask

	task summarize;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_latch;
		chk({wr_en_latch, power_down, four_line_command_mode}, 3'b000);
		run('{OP_WR_ENABLE}, 8);
		chk(wr_en_latch, 1);
		run('{OP_WR_DISABLE}, 8);
		chk(wr_en_latch, 0);
		run('{OP_WR_ENABLE}, 9);
		chk(wr_en_latch, 0);
		run('{OP_VOL_WR_ENABLE}, 8);
		g0 = sr_n;
		run('{OP_STAT_WRITE, 8'h3c, 8'h81}, 24);
		chk(sr_n - g0, 1);
		chk({sr_wr_data, sr_wr_hi_en, sr_wr_volatile}, {16'h813c, 2'b11});
		$display("test latch done");
	endtask

	task automatic t_erase;
		logic [7:0] op[5] = '{OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K, OP_CHIP_ERASE_A,
			OP_CHIP_ERASE_B};
		sfe_op_t ex[5] = '{SFE_OP_ERASE_4K, SFE_OP_ERASE_32K, SFE_OP_ERASE_64K,
			SFE_OP_ERASE_CHIP, SFE_OP_ERASE_CHIP};
		for (int i = 0; i < 5; i++) begin
			run('{OP_WR_ENABLE}, 8);
			g0 = go_n;
			run('{op[i], 8'h12, 8'h34, 8'h56}, (i < 3) ? 32 : 8);
			chk(go_n - g0, 1);
			chk(go_op, ex[i]);
			chk({wr_en_latch, (i < 3) ? go_addr : 24'h123456}, {1'b0, 24'h123456});
		end
		prot_en <= 1'b1;
		prot_lo <= 24'h120000;
		prot_hi <= 24'h12ffff;
		run('{OP_WR_ENABLE}, 8);
		g0 = go_n;
		run('{OP_ERASE_4K, 8'h12, 8'h34, 8'h56}, 32);
		chk(go_n - g0, 0);
		run('{OP_ERASE_4K, 8'h20, 8'h00, 8'h00}, 31);
		chk(go_n - g0, 0);
		run('{OP_ERASE_4K, 8'h20, 8'h00, 8'h00}, 32);
		chk(go_n - g0, 1);
		prot_en <= 1'b0;
		$display("test erase done");
	endtask

	task t_busy;
		busy <= 1'b1;
		status_hi <= 8'ha5;
		run('{OP_WR_ENABLE}, 8);
		chk(wr_en_latch, 0);
		run('{OP_STAT_LO_READ}, 16);
		chk(rx[1], 8'h01);
		g0 = go_n;
		run('{OP_SUSPEND}, 8);
		chk({go_n - g0, go_op}, {32'd1, SFE_OP_SUSPEND});
		run('{OP_RESUME}, 8);
		chk({go_n - g0, go_op}, {32'd2, SFE_OP_RESUME});
		busy <= 1'b0;
		run('{OP_STAT_HI_READ}, 16);
		chk(rx[1], 8'ha5);
		$display("test busy done");
	endtask

	task t_read;
		run('{OP_READ, 8'h00, 8'h10, 8'hf0}, 48);
		chk({rx[4], rx[5]}, {8'hcc, 8'hcd});
		run('{OP_FAST_READ, 8'h00, 8'h10, 8'h20}, 56);
		chk(rx[5], 8'h1c);
		run('{OP_READ, 8'h00, 8'h00, 8'h00}, 37);
		chk(serial_out_oe, 0);
		run('{OP_WR_ENABLE}, 8);
		chk(wr_en_latch, 1);
		run('{OP_WR_DISABLE}, 8);
		$display("test read done");
	endtask

	task t_pdown;
		run('{OP_POWER_DOWN}, 8);
		chk(power_down, 1);
		run('{OP_WR_ENABLE}, 8);
		chk(wr_en_latch, 0);
		run('{OP_WAKE_ID, 8'h00, 8'h00, 8'h00}, 40);
		chk({rx[4], power_down}, {DEVC, 1'b0});
		g0 = go_n;
		run('{OP_RESET_GO}, 8);
		chk(go_n - g0, 0);
		run('{OP_RESET_ARM}, 8);
		run('{OP_RESET_GO}, 8);
		chk({go_n - g0, go_op}, {32'd1, SFE_OP_RESET});
		$display("test pdown done");
	endtask

	task t_quad;
		run('{OP_QUAD_ON}, 8);
		chk(four_line_command_mode, 1);
		h.quad = 1'b1;
		run('{OP_WR_ENABLE}, 8);
		chk(wr_en_latch, 1);
		run('{OP_READ, 8'h00, 8'h00, 8'h5a}, 48);
		chk({rx[4], rx[5]}, {8'h66, 8'h67});
		run('{OP_WR_DISABLE}, 8);
		run('{OP_QUAD_OFF}, 8);
		chk({four_line_command_mode, wr_en_latch}, 2'b00);
		h.quad = 1'b0;
		$display("test quad done");
	endtask

	task t_prog;
		prog_ready <= 1'b0;
		pq = {};
		run('{OP_WR_ENABLE}, 8);
		g0 = go_n;
		run('{OP_PAGE_PROG, 8'h00, 8'h01, 8'h00, 8'ha1, 8'hb2}, 48);
		chk({go_n - g0, go_op}, {32'd1, SFE_OP_PROGRAM});
		chk({prog_valid, prog_data, pq.size()}, {1'b1, 8'ha1, 32'd0});
		prog_ready <= 1'b1;
		repeat (6) @(posedge clk_sys);
		chk({prog_valid, pq.size(), pq[0], pq[1]}, {1'b0, 32'd2, 8'ha1, 8'hb2});
		$display("test program done");
	endtask

	// watchdog
	initial begin
		#6000000;
		err_total++;
		summarize;
	end

	// main sequence
	initial begin
		repeat (5) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		t_latch;
		t_erase;
		t_busy;
		t_read;
		t_pdown;
		t_quad;
		t_prog;
		summarize;
	end
endmodule

`default_nettype wire

// ==== testbench/sfe_frontend_chk.sv ====
// sfe_frontend_chk: port assertions of the front end.
// assumes: bound to sfe_frontend; single clk_sys domain.
`timescale 1ns/10ps
`default_nettype none

module sfe_frontend_chk (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// watched ports
	input wire logic spi_cs_n,
	input wire logic busy,
	input wire logic serial_out_oe,
	input wire logic [3:0] io_oe,
	input wire logic rd_req,
	input wire logic prog_valid,
	input wire logic [7:0] prog_data,
	input wire logic prog_ready,
	input wire logic cmd_go,
	input wire sfe_pkg::sfe_op_t cmd_op,
	input wire logic sr_wr,
	input wire logic wr_en_latch,
	input wire logic power_down,
	input wire logic four_line_command_mode
);
	import sfe_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	go_at_cs_a: assert property (cmd_go |-> spi_cs_n && $past(spi_cs_n, 2))
		else $error("go with cs low");
	go_pulse_a: assert property (cmd_go |=> !cmd_go)
		else $error("go too long");
	sr_at_cs_a: assert property (sr_wr |-> spi_cs_n)
		else $error("sr write with cs low");
	rd_pulse_a: assert property (rd_req |=> !rd_req)
		else $error("rd_req too long");
	oe_idle_a: assert property (spi_cs_n [*4] |-> !serial_out_oe && io_oe == 4'h0)
		else $error("oe after frame");
	busy_go_a: assert property (cmd_go && busy |-> cmd_op inside {SFE_OP_SUSPEND, SFE_OP_RESUME})
		else $error("go while busy");
	wel_rise_a: assert property ($rose(wr_en_latch) |-> spi_cs_n && !busy)
		else $error("bad latch set");
	pd_go_a: assert property (cmd_go |-> !power_down)
		else $error("go in power-down");
	quad_oe_a: assert property (io_oe != 4'h0 |-> four_line_command_mode && !serial_out_oe)
		else $error("quad oe misuse");
	single_oe_a: assert property (serial_out_oe |-> !four_line_command_mode)
		else $error("single oe in quad");
	prog_hold_a: assert property (prog_valid && !prog_ready |=> prog_valid && $stable(prog_data))
		else $error("stall lost byte");

	// main scenarios seen
	cover property (cmd_go);
	cover property (rd_req);
	cover property (prog_valid && !prog_ready);
endmodule

bind sfe_frontend sfe_frontend_chk u_chk (.clk_sys, .reset_n, .spi_cs_n, .busy, .serial_out_oe,
	.io_oe, .rd_req, .prog_valid, .prog_data, .prog_ready, .cmd_go, .cmd_op, .sr_wr,
	.wr_en_latch, .power_down, .four_line_command_mode);

`default_nettype wire

// ==== testbench/sfe_host.sv ====
// sfe_host: behavioural spi host driving frames at the pins.
// assumes: clk_sys free running; sclk high for four clk_sys cycles, low for eight.
`timescale 1ns/10ps
`default_nettype none

module sfe_host (
	// clock
	input wire logic clk_sys,
	// pins to the device
	output logic spi_cs_n,
	output logic spi_sclk,
	output logic serial_in,
	output logic [3:0] io_in,
	// pins from the device
	input wire logic serial_out,
	input wire logic [3:0] io_out
);
	logic quad;

	// idle pins at time zero
	initial begin
		spi_cs_n = 1'b1;
		spi_sclk = 1'b0;
		serial_in = 1'b0;
		io_in = 4'h0;
		quad = 1'b0;
	end

	// one frame of bits clocked bits long; sclk idles low
	task automatic frame(input logic [7:0] tx[$], input int bits, output logic [7:0] rx[$]);
		int k;
		int st;
		logic [7:0] b;
		logic [7:0] r;
		rx = {};
		r = 8'h00;
		st = quad ? 4 : 1;
		spi_cs_n <= 1'b0;
		for (k = 0; k < bits; k += st) begin
			b = (k / 8 < tx.size()) ? tx[k / 8] : 8'h00;
			b = b << (k % 8); // msb or upper nibble first
			repeat (4) @(posedge clk_sys);
			serial_in <= b[7];
			io_in <= b[7:4];
			repeat (4) @(posedge clk_sys);
			spi_sclk <= 1'b1;
			r = quad ? {r[3:0], io_out} : {r[6:0], serial_out};
			if ((k + st) % 8 == 0)
				rx.push_back(r);
			repeat (4) @(posedge clk_sys);
			spi_sclk <= 1'b0;
		end
		repeat (4) @(posedge clk_sys);
		spi_cs_n <= 1'b1;
		serial_in <= ~serial_in; // released lines flip
		io_in <= ~io_in;
		repeat (6) @(posedge clk_sys);
	endtask
endmodule

`default_nettype wire

// ==== verilog/sfe_buf2.sv ====
// sfe_buf2: small valid/ready buffer for program data bytes.
// assumes: one clock.
`timescale 1ns/10ps
`default_nettype none

module sfe_buf2 #(
	parameter int W = 8,
	parameter int DEPTH = 2
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// fill side
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	// drain side
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	logic [W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q, rd_q;
	logic [AW:0] cnt_q, cnt_d;
	logic full_q, empty_q, push, pop;

	assign push = in_valid & ~full_q;
	assign pop = out_ready & ~empty_q;
	assign in_ready = ~full_q;
	assign out_valid = ~empty_q;
	assign out_data = mem_q[rd_q];

	// occupancy after this cycle
	always_comb begin
		cnt_d = cnt_q;
		if (push & ~pop) cnt_d = cnt_q + 1'b1;
		if (pop & ~push) cnt_d = cnt_q - 1'b1;
	end

	// pointers and flags
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			full_q <= 1'b0;
			empty_q <= 1'b1;
		end else begin
			if (push) wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
			if (pop) rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
			cnt_q <= cnt_d;
			full_q <= (cnt_d == FULL_CNT);
			empty_q <= (cnt_d == '0);
		end
	end

	// storage
	always_ff @(posedge clk_sys) begin
		if (push) mem_q[wr_q] <= in_data;
	end
endmodule

`default_nettype wire

// ==== verilog/sfe_frontend.sv ====
// sfe_frontend: instruction front end of a serial nor flash.
// assumes: sclk phases of at least three clk_sys cycles;
// rd_data answers rd_req one cycle later;
// sclk idles low.
// Function
// (RULE1) cs falling starts frame; first byte opcode
// (RULE2) single-line: sample rising edge, msb first
// (RULE3) four-line mode takes opcode on all lines
// (RULE4) four-line: byte per two clocks, upper nibble
// (RULE5) act on command only at cs rise
// (RULE6) reads end anywhere; output stops at cs
// (RULE7) writes need whole bytes, else discarded
// (RULE8) busy: ignore all but status read; code takes only 05h, 75h and 7ah
// (RULE9) drop program/erase touching protected area
// (RULE10) 06h set, 04h clear latch, 50h volatile
// (RULE11) 75h suspends, 7ah resumes array operation
// (RULE12) abh wakes, returns code after dummies; b9h
// (RULE13) 24-bit address, three bytes, msb first
// (RULE14) 03h reads at once; 0bh one dummy
// (RULE15) erase opcodes 20h 52h d8h c7h 60h
// (RULE16) 05h/35h read status; 01h writes lo,hi
// (RULE17) 66h then 99h resets; 38h four-line
`timescale 1ns/10ps
`default_nettype none

module sfe_frontend #(
	parameter logic [7:0] DEV_CODE = 8'h5a, // arbitrary value
	parameter int BUF_DEPTH = 2
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// serial pins
	input wire logic spi_cs_n,
	input wire logic spi_sclk,
	input wire logic serial_in,
	input wire logic [3:0] io_in,
	output logic serial_out,
	output logic serial_out_oe,
	output logic [3:0] io_out,
	output logic [3:0] io_oe,
	// array engine state
	input wire logic busy,
	input wire logic [7:0] status_lo,
	input wire logic [7:0] status_hi,
	input wire logic prot_en,
	input wire logic [23:0] prot_lo,
	input wire logic [23:0] prot_hi,
	// array read
	output logic rd_req,
	output logic [23:0] rd_addr,
	input wire logic [7:0] rd_data,
	// program data stream
	output logic prog_valid,
	output logic [7:0] prog_data,
	input wire logic prog_ready,
	// commands to the array engine
	output logic cmd_go,
	output sfe_pkg::sfe_op_t cmd_op,
	output logic [23:0] cmd_addr,
	output logic sr_wr,
	output logic [15:0] sr_wr_data,
	output logic sr_wr_hi_en,
	output logic sr_wr_volatile,
	// mode flags
	output logic wr_en_latch,
	output logic power_down,
	output logic four_line_command_mode
);
	import sfe_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------

	// commands that must end on a byte boundary
	function automatic logic is_write_op(input logic [7:0] op);
		is_write_op = (op == OP_WR_ENABLE) || (op == OP_WR_DISABLE) ||
			(op == OP_VOL_WR_ENABLE) || (op == OP_STAT_WRITE) ||
			(op == OP_PAGE_PROG) || (op == OP_ERASE_4K) ||
			(op == OP_ERASE_32K) || (op == OP_ERASE_64K) ||
			(op == OP_CHIP_ERASE_A) || (op == OP_CHIP_ERASE_B);
	endfunction

	// size of the region a program or erase touches
	function automatic logic [23:0] op_mask(input logic [7:0] op);
		case (op)
			OP_PAGE_PROG: op_mask = MASK_PAGE;
			OP_ERASE_4K: op_mask = MASK_4K;
			OP_ERASE_32K: op_mask = MASK_32K;
			OP_ERASE_64K: op_mask = MASK_64K;
			default: op_mask = MASK_CHIP;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers and edges
	// ----------------------------------------------------------------
	logic cs_s, sclk_s, si_s;
	logic [3:0] io_s;
	logic cs_prev_q, sclk_prev_q;
	logic cs_fall, cs_rise, rise, fall;

	sfe_sync #(.W(1), .RST(RST_CS_N)) u_sync_cs (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.d(spi_cs_n),
		.q(cs_s)
	);

	sfe_sync #(.W(6), .RST(6'h00)) u_sync_dat (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.d({spi_sclk, serial_in, io_in}),
		.q({sclk_s, si_s, io_s})
	);

	// previous levels for edge detection
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cs_prev_q <= RST_CS_N;
			sclk_prev_q <= 1'b0;
		end else begin
			cs_prev_q <= cs_s;
			sclk_prev_q <= sclk_s;
		end
	end

	assign cs_fall = ~cs_s & cs_prev_q;
	assign cs_rise = cs_s & ~cs_prev_q;
	assign rise = sclk_s & ~sclk_prev_q & ~cs_s;
	assign fall = ~sclk_s & sclk_prev_q & ~cs_s;

	// ----------------------------------------------------------------
	// input framing
	// ----------------------------------------------------------------
	logic quad_q, wel_q, vwe_q, pd_q, rst_arm_q, overrun_q;
	logic [7:0] shift_q, shift_d, opcode_q, cur_op;
	logic [2:0] bit_cnt_q, bit_step, bit_next;
	logic [3:0] byte_cnt_q;
	logic byte_done, ignore_q, block_op, live;
	logic [23:0] addr_q;
	logic [15:0] sr_buf_q;

	// one bit or one nibble per rising edge, msb first
	assign shift_d = quad_q ? {shift_q[3:0], io_s} // [RULE3] [RULE4]
		: {shift_q[6:0], si_s}; // [RULE2]
	assign bit_step = quad_q ? 3'h4 : 3'h1; // [RULE4]
	assign bit_next = bit_cnt_q + bit_step;
	assign byte_done = rise & (bit_next == 3'h0);
	assign cur_op = (byte_cnt_q == 4'h0) ? shift_d : opcode_q;

	// opcodes refused by a busy or sleeping device
	assign block_op = (busy & (shift_d != OP_STAT_LO_READ) & // [RULE8]
		(shift_d != OP_SUSPEND) & (shift_d != OP_RESUME)) |
		(pd_q & (shift_d != OP_WAKE_ID));
	assign live = byte_done &
		~((byte_cnt_q == 4'h0) ? block_op : ignore_q);

	// bit and byte counters, opcode capture
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			shift_q <= 8'h00;
			bit_cnt_q <= 3'h0;
			byte_cnt_q <= 4'h0;
			opcode_q <= 8'h00;
			ignore_q <= 1'b0;
		end else if (cs_fall) begin
			bit_cnt_q <= 3'h0; // [RULE1]
			byte_cnt_q <= 4'h0;
			ignore_q <= 1'b0;
		end else if (rise) begin
			shift_q <= shift_d;
			bit_cnt_q <= bit_next;
			if (byte_done && byte_cnt_q != IDX_SAT) byte_cnt_q <= byte_cnt_q + 4'h1;
			if (byte_done && byte_cnt_q == 4'h0) begin
				opcode_q <= shift_d; // [RULE1]
				ignore_q <= block_op; // [RULE8]
			end
		end
	end

	// address and status payload capture
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			addr_q <= 24'h000000;
			sr_buf_q <= 16'h0000;
		end else if (byte_done) begin
			if (opcode_q == OP_STAT_WRITE) begin
				if (byte_cnt_q == IDX_STAT_LO) sr_buf_q[7:0] <= shift_d; // [RULE16]
				if (byte_cnt_q == IDX_STAT_HI) sr_buf_q[15:8] <= shift_d; // [RULE16]
			end else if (byte_cnt_q >= IDX_ADDR_FIRST && byte_cnt_q <= IDX_ADDR_LAST) begin
				addr_q <= {addr_q[15:0], shift_d}; // [RULE13]
			end
		end
	end

	// ----------------------------------------------------------------
	// output data path
	// ----------------------------------------------------------------
	logic [7:0] out_q, load_val, stat_lo;
	logic load_now, req_now, req_first, hold_q;
	logic rd_req_q, rd_load_q, so_oe_q;
	logic [3:0] io_oe_q;
	logic [23:0] rd_addr_q, req_base;

	// pick the byte to send after this boundary
	always_comb begin
		stat_lo = status_lo;
		stat_lo[SR_WEL_POS] = wel_q;
		stat_lo[SR_BUSY_POS] = busy;
		load_now = 1'b0;
		load_val = 8'h00;
		req_now = 1'b0;
		req_first = 1'b0;
		req_base = addr_q;
		if (live) begin
			case (cur_op)
				OP_STAT_LO_READ: begin
					load_now = 1'b1; // [RULE16]
					load_val = stat_lo;
				end
				OP_STAT_HI_READ: begin
					load_now = 1'b1; // [RULE16]
					load_val = status_hi;
				end
				OP_WAKE_ID: begin
					load_now = (byte_cnt_q >= IDX_WAKE_DATA); // [RULE12]
					load_val = DEV_CODE;
				end
				OP_READ: begin
					req_now = (byte_cnt_q >= IDX_ADDR_LAST); // [RULE14]
					req_first = (byte_cnt_q == IDX_ADDR_LAST);
					req_base = {addr_q[15:0], shift_d};
				end
				OP_FAST_READ: begin
					req_now = (byte_cnt_q >= IDX_FAST_DATA); // [RULE14]
					req_first = (byte_cnt_q == IDX_FAST_DATA);
				end
				default: begin
					load_now = 1'b0;
				end
			endcase
		end
	end

	// array read requests, one byte ahead of the shifter
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rd_req_q <= 1'b0;
			rd_load_q <= 1'b0;
			rd_addr_q <= 24'h000000;
		end else begin
			rd_req_q <= req_now;
			rd_load_q <= rd_req_q & ~cs_s;
			if (req_now) rd_addr_q <= req_first ? req_base : rd_addr_q + 24'h000001;
		end
	end

	// shifter: load at boundary, hold one falling edge, then shift
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			out_q <= 8'h00;
			hold_q <= 1'b0;
			so_oe_q <= 1'b0;
			io_oe_q <= 4'h0;
		end else if (cs_s) begin
			so_oe_q <= 1'b0; // [RULE6]
			io_oe_q <= 4'h0; // [RULE6]
			hold_q <= 1'b0;
		end else if (load_now || rd_load_q) begin
			out_q <= load_now ? load_val : rd_data;
			hold_q <= 1'b1;
			so_oe_q <= ~quad_q;
			io_oe_q <= {4{quad_q}}; // [RULE4]
		end else if (fall && (so_oe_q || io_oe_q[0])) begin
			if (hold_q) hold_q <= 1'b0;
			else if (quad_q) out_q <= {out_q[3:0], 4'h0}; // [RULE4]
			else out_q <= {out_q[6:0], 1'b0};
		end
	end

	// ----------------------------------------------------------------
	// program data into the buffer
	// ----------------------------------------------------------------
	logic push_q, buf_in_ready;
	logic [7:0] push_data_q;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			push_q <= 1'b0;
			push_data_q <= 8'h00;
			overrun_q <= 1'b0;
		end else begin
			push_q <= live & (opcode_q == OP_PAGE_PROG) &
				(byte_cnt_q >= IDX_PROG_DATA) & wel_q;
			push_data_q <= shift_d;
			if (cs_fall) overrun_q <= 1'b0;
			else if (push_q && !buf_in_ready) overrun_q <= 1'b1;
		end
	end

	sfe_buf2 #(.W(8), .DEPTH(BUF_DEPTH)) u_buf (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.in_valid(push_q),
		.in_data(push_data_q),
		.in_ready(buf_in_ready),
		.out_valid(prog_valid),
		.out_data(prog_data),
		.out_ready(prog_ready)
	);

	// ----------------------------------------------------------------
	// end of frame: decide and act
	// ----------------------------------------------------------------
	logic act, whole, done_ok, hit;
	logic [23:0] reg_lo, reg_hi;
	logic go_d, sr_go;
	sfe_op_t op_d;

	assign act = cs_rise & (byte_cnt_q != 4'h0) & ~ignore_q; // [RULE5]
	assign whole = (bit_cnt_q == 3'h0);
	assign done_ok = act & (~is_write_op(opcode_q) | whole); // [RULE7]
	assign reg_lo = addr_q & ~op_mask(opcode_q);
	assign reg_hi = addr_q | op_mask(opcode_q);
	assign hit = prot_en & (reg_lo <= prot_hi) & (reg_hi >= prot_lo); // [RULE9]
	assign sr_go = done_ok & (opcode_q == OP_STAT_WRITE) & (wel_q | vwe_q) &
		(byte_cnt_q > IDX_STAT_LO);

	// array operation to launch
	always_comb begin
		go_d = 1'b0;
		op_d = SFE_OP_NONE;
		case (opcode_q)
			OP_PAGE_PROG: begin
				if (done_ok && wel_q && byte_cnt_q > IDX_PROG_DATA && !hit && !overrun_q) begin
					go_d = 1'b1; // [RULE9]
					op_d = SFE_OP_PROGRAM;
				end else if (cs_rise && byte_cnt_q > IDX_PROG_DATA) begin
					go_d = 1'b1; // [RULE7]
					op_d = SFE_OP_CANCEL;
				end
			end
			OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K: begin
				go_d = done_ok & wel_q & (byte_cnt_q == IDX_ADDR_LAST + 4'h1) & ~hit; // [RULE15]
				op_d = (opcode_q == OP_ERASE_4K) ? SFE_OP_ERASE_4K :
					(opcode_q == OP_ERASE_32K) ? SFE_OP_ERASE_32K : SFE_OP_ERASE_64K;
			end
			OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
				go_d = done_ok & wel_q & (byte_cnt_q == 4'h1) & ~prot_en; // [RULE15] [RULE9]
				op_d = SFE_OP_ERASE_CHIP;
			end
			OP_SUSPEND: begin
				go_d = done_ok; // [RULE11]
				op_d = SFE_OP_SUSPEND;
			end
			OP_RESUME: begin
				go_d = done_ok; // [RULE11]
				op_d = SFE_OP_RESUME;
			end
			OP_RESET_GO: begin
				go_d = done_ok & rst_arm_q; // [RULE17]
				op_d = SFE_OP_RESET;
			end
			default: begin
				go_d = 1'b0;
			end
		endcase
	end

	// launch pulses toward the array engine
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cmd_go <= 1'b0;
			cmd_op <= SFE_OP_NONE;
			cmd_addr <= 24'h000000;
			sr_wr <= 1'b0;
			sr_wr_data <= 16'h0000;
			sr_wr_hi_en <= 1'b0;
			sr_wr_volatile <= 1'b0;
		end else begin
			cmd_go <= go_d;
			if (go_d) cmd_op <= op_d;
			if (go_d) cmd_addr <= addr_q;
			sr_wr <= sr_go; // [RULE16]
			if (sr_go) begin
				sr_wr_data <= sr_buf_q;
				sr_wr_hi_en <= (byte_cnt_q > IDX_STAT_HI);
				sr_wr_volatile <= vwe_q & ~wel_q;
			end
		end
	end

	// latches and modes changed by finished commands
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wel_q <= RST_WEL;
			vwe_q <= 1'b0;
			quad_q <= RST_QUAD;
			pd_q <= RST_PDOWN;
			rst_arm_q <= 1'b0;
		end else if (done_ok) begin
			rst_arm_q <= (opcode_q == OP_RESET_ARM); // [RULE17]
			case (opcode_q)
				OP_WR_ENABLE: wel_q <= 1'b1; // [RULE10]
				OP_WR_DISABLE: wel_q <= 1'b0; // [RULE10]
				OP_VOL_WR_ENABLE: vwe_q <= 1'b1; // [RULE10]
				OP_QUAD_ON: quad_q <= 1'b1; // [RULE17]
				OP_QUAD_OFF: quad_q <= 1'b0;
				OP_POWER_DOWN: pd_q <= 1'b1; // [RULE12]
				OP_WAKE_ID: pd_q <= 1'b0; // [RULE12]
				OP_RESET_GO: begin
					if (rst_arm_q) begin
						wel_q <= RST_WEL; // [RULE17]
						vwe_q <= 1'b0;
						quad_q <= RST_QUAD;
					end
				end
				default: begin
					if (go_d && op_d != SFE_OP_SUSPEND && op_d != SFE_OP_RESUME) wel_q <= 1'b0;
					if (sr_go) begin
						wel_q <= 1'b0;
						vwe_q <= 1'b0;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign serial_out = out_q[7]; // [RULE2]
	assign serial_out_oe = so_oe_q;
	assign io_out = out_q[7:4]; // [RULE4]
	assign io_oe = io_oe_q;
	assign rd_req = rd_req_q;
	assign rd_addr = rd_addr_q;
	assign wr_en_latch = wel_q;
	assign power_down = pd_q;
	assign four_line_command_mode = quad_q;
endmodule

`default_nettype wire

// ==== verilog/sfe_pkg.sv ====
// sfe_pkg: opcodes, positions, masks and reset values.
// assumes: compiled before the other design files.
`default_nettype none

package sfe_pkg;

	// ----------------------------------------------------------------
	// operation codes
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_WR_ENABLE = 8'h06;
	localparam logic [7:0] OP_WR_DISABLE = 8'h04;
	localparam logic [7:0] OP_VOL_WR_ENABLE = 8'h50;
	localparam logic [7:0] OP_STAT_LO_READ = 8'h05;
	localparam logic [7:0] OP_STAT_HI_READ = 8'h35;
	localparam logic [7:0] OP_STAT_WRITE = 8'h01;
	localparam logic [7:0] OP_PAGE_PROG = 8'h02;
	localparam logic [7:0] OP_ERASE_4K = 8'h20;
	localparam logic [7:0] OP_ERASE_32K = 8'h52;
	localparam logic [7:0] OP_ERASE_64K = 8'hd8;
	localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
	localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
	localparam logic [7:0] OP_SUSPEND = 8'h75;
	localparam logic [7:0] OP_RESUME = 8'h7a;
	localparam logic [7:0] OP_POWER_DOWN = 8'hb9;
	localparam logic [7:0] OP_WAKE_ID = 8'hab;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FAST_READ = 8'h0b;
	localparam logic [7:0] OP_QUAD_ON = 8'h38;
	localparam logic [7:0] OP_QUAD_OFF = 8'hff;
	localparam logic [7:0] OP_RESET_ARM = 8'h66;
	localparam logic [7:0] OP_RESET_GO = 8'h99;

	// ----------------------------------------------------------------
	// byte positions inside a frame, status fields, region masks
	// ----------------------------------------------------------------
	localparam logic [3:0] IDX_ADDR_FIRST = 4'h1;
	localparam logic [3:0] IDX_ADDR_LAST = 4'h3;
	localparam logic [3:0] IDX_FAST_DATA = 4'h4;
	localparam logic [3:0] IDX_WAKE_DATA = 4'h3;
	localparam logic [3:0] IDX_PROG_DATA = 4'h4;
	localparam logic [3:0] IDX_STAT_LO = 4'h1;
	localparam logic [3:0] IDX_STAT_HI = 4'h2;
	localparam logic [3:0] IDX_SAT = 4'hf;
	localparam int SR_BUSY_POS = 0;
	localparam int SR_WEL_POS = 1;
	localparam logic [23:0] MASK_PAGE = 24'h0000ff;
	localparam logic [23:0] MASK_4K = 24'h000fff;
	localparam logic [23:0] MASK_32K = 24'h007fff;
	localparam logic [23:0] MASK_64K = 24'h00ffff;
	localparam logic [23:0] MASK_CHIP = 24'hffffff;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic RST_QUAD = 1'b0;
	localparam logic RST_WEL = 1'b0;
	localparam logic RST_PDOWN = 1'b0;
	localparam logic RST_CS_N = 1'b1;

	// operation handed to the array engine
	typedef enum logic [3:0] {
		SFE_OP_NONE,
		SFE_OP_PROGRAM,
		SFE_OP_ERASE_4K,
		SFE_OP_ERASE_32K,
		SFE_OP_ERASE_64K,
		SFE_OP_ERASE_CHIP,
		SFE_OP_SUSPEND,
		SFE_OP_RESUME,
		SFE_OP_RESET,
		SFE_OP_CANCEL
	} sfe_op_t;

endpackage

`default_nettype wire

// ==== verilog/sfe_sync.sv ====
// sfe_sync: two flip-flop synchroniser for pin levels.
// assumes: inputs are asynchronous levels, not pulses.
`timescale 1ns/10ps
`default_nettype none

module sfe_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	// first stage feeds only the second
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= RST;
			q <= RST;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule

`default_nettype wire
